// ---- dlt_pkg.sv ----
// Constants and types of the display linearizer and teach sequencer
package dlt_pkg;
  localparam int VAL_W = 18;
  localparam int NPTS  = 16;
  localparam int RAW_W = 16;

  // ------------------------------------------------------------------
  // Value range and thresholds
  // ------------------------------------------------------------------
  localparam logic signed [VAL_W-1:0] VAL_MAX = 18'sh1_869F;
  localparam logic signed [VAL_W-1:0] VAL_MIN = 18'sh2_7961;
  // Raw inputs in mV (voltage range) or uA (current range)
  localparam logic signed [RAW_W-1:0] V_OVER  = 16'sh27D8;
  localparam logic signed [RAW_W-1:0] V_UNDER = 16'shD828;
  localparam logic signed [RAW_W-1:0] I_OVER  = 16'sh4FB0;
  localparam logic signed [RAW_W-1:0] I_UNDER = 16'shFE70;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS          = 32'h0000_0019;
  localparam int TICK_NS         = 32'h000F_4240;
  localparam int TICK_CYC        = TICK_NS / CLK_NS;
  localparam int T_HOLD_TEACH_MS = 32'h0000_0BB8;
  localparam int T_HOLD_STOP_MS  = 32'h0000_07D0;
  localparam int T_IDLE_MS       = 32'h0000_2710;
  localparam int T_YLBL_MS       = 32'h0000_03E8;
  localparam int T_STOP_MS       = 32'h0000_07D0;
  localparam int T_STOP_SHORT_MS = 32'h0000_01F4;
  localparam int MS_TICKS        = TICK_NS / 32'h000F_4240;
  localparam logic [13:0] HOLD_TEACH_TK = 14'(T_HOLD_TEACH_MS * MS_TICKS);
  localparam logic [13:0] HOLD_STOP_TK  = 14'(T_HOLD_STOP_MS * MS_TICKS);
  localparam logic [13:0] IDLE_TK       = 14'(T_IDLE_MS * MS_TICKS);
  localparam logic [13:0] YLBL_TK       = 14'(T_YLBL_MS * MS_TICKS);
  localparam logic [13:0] STOP_TK       = 14'(T_STOP_MS * MS_TICKS);
  localparam logic [13:0] STOP_SHORT_TK = 14'(T_STOP_SHORT_MS * MS_TICKS);

  // ------------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_OFFS   = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_DISP   = 8'h0C;
  localparam logic [7:0] A_PT_LO  = 8'h40;
  localparam logic [7:0] A_PT_HI  = 8'hBC;
  localparam int F_OPMODE = 32'h0000_0000;
  localparam int F_CMDFN  = 32'h0000_0003;
  localparam int F_LINMD  = 32'h0000_0005;
  localparam int F_CUR_A  = 32'h0000_0007;
  localparam int F_CUR_B  = 32'h0000_0008;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [1:0] CMD_TARE  = 2'h1;
  localparam logic [1:0] CMD_TEACH = 2'h2;
  localparam logic [1:0] CMD_BOTH  = 2'h3;
  localparam logic [1:0] LIN_ONE_QUAD  = 2'h1;
  localparam logic [1:0] LIN_FOUR_QUAD = 2'h2;
  localparam logic [2:0] OP_DUAL = 3'h1;

  // ------------------------------------------------------------------
  // Display message codes; 1..8 are the range combinations
  // ------------------------------------------------------------------
  localparam logic [3:0] MSG_VALUE = 4'h0;
  localparam logic [3:0] MSG_TEACH = 4'h9;
  localparam logic [3:0] MSG_STOP  = 4'hA;
  localparam logic [3:0] MSG_XLBL  = 4'hB;
  localparam logic [3:0] MSG_YLBL  = 4'hC;
  localparam logic [3:0] MSG_ERR   = 4'hD;

  typedef logic signed [VAL_W-1:0] dlt_val_type;
  typedef dlt_val_type [NPTS-1:0] dlt_pts_type;
  typedef enum logic [3:0] {
    ST_NORMAL, ST_ARMED, ST_XLBL, ST_LIVE, ST_YLBL, ST_YEDIT, ST_ERR, ST_STOP
  } dlt_st_type;

  typedef struct packed {
    dlt_val_type val;
    logic [3:0]  msg;
    logic [3:0]  point;
    logic        blink;
  } dlt_disp_type;

  typedef struct packed {
    dlt_st_type   st;
    logic [8:0]   ctrl;
    dlt_val_type  offs;
    dlt_pts_type  px;
    dlt_pts_type  py;
    dlt_pts_type  sx;
    dlt_pts_type  sy;
    logic [3:0]   idx;
    dlt_val_type  edit;
    logic [15:0]  pre;
    logic [13:0]  tmr;
    logic [13:0]  hold;
    logic         cmd_q;
    logic         ent_q;
    dlt_disp_type disp;
    logic [31:0]  prdata;
    logic         perr;
  } dlt_state_type;
endpackage

// ---- dlt_linearizer.sv ----
// Tare, 16-point linearizer, teach sequencer and range messages
//
// Operation
// - Command press with tare function copies the untared measured value to offset.
// - Sixteen free points, straight-line interpolation between neighbours.
// - Linearize only in one- or four-quadrant mode, else pass through.
// - Output the paired y value in place of an x value.
// - Bus-written and captured x coordinates hold -99999 to 99999; edited y values are not limited.
// - Below the first x the first y is output.
// - Above the last x the last y is output.
// - Single and dual modes linearize channel A only.
// - Combined modes linearize the combined result.
// - Teach starts only with teach or both command function.
// - Command held 3 s enters teach and shows the banner.
// - Enter held 2 s before start shows stop, exits unchanged.
// - Ten idle seconds in teach before start return to normal unchanged.
// - Command press starts procedure, shows x label, presets points.
// - Press shows live; next captures x, y label 1 s, then edit.
// - Command press stores edited y and moves to next x label.
// - Non-rising x blinks decimal points; press refused with error.
// - After point sixteen the sequence wraps to the first point.
// - Enter in procedure shows stop 2 s and commits points.
// - Flag overflow and underflow per channel against range limits.
// - Distinct message for each of eight out-of-range combinations.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dlt_linearizer #(
  parameter int TICK_CYCLES = dlt_pkg::TICK_CYC
) (
  input  wire logic                  CLOCK,
  input  wire logic                  ARST_N,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire dlt_pkg::dlt_val_type  MEAS_A,
  input  wire dlt_pkg::dlt_val_type  MEAS_COMB,
  input  wire logic signed [15:0]    RAW_A,
  input  wire logic signed [15:0]    RAW_B,
  input  wire logic                  KEY_CMD,
  input  wire logic                  KEY_ENTER,
  input  wire dlt_pkg::dlt_val_type  EDIT_VALUE,
  input  wire logic                  EDIT_LOAD,
  output dlt_pkg::dlt_disp_type      DISP
);
  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic dlt_pkg::dlt_val_type sat(input logic signed [39:0] v);
    if (v > 40'(dlt_pkg::VAL_MAX)) return dlt_pkg::VAL_MAX;
    if (v < 40'(dlt_pkg::VAL_MIN)) return dlt_pkg::VAL_MIN;
    return dlt_pkg::VAL_W'(v);
  endfunction

  function automatic dlt_pkg::dlt_val_type lin(input dlt_pkg::dlt_val_type v,
                                               input dlt_pkg::dlt_pts_type xs,
                                               input dlt_pkg::dlt_pts_type ys);
    logic [3:0]         k;
    logic signed [39:0] dx;
    logic signed [39:0] q;
    k  = '0;
    dx = '0;
    q  = '0;
    if (v < xs[0]) return ys[0];
    if (v > xs[dlt_pkg::NPTS-1]) return ys[dlt_pkg::NPTS-1];
    for (int i = 0; i < dlt_pkg::NPTS - 1; i++) begin
      if (v >= xs[i] && v <= xs[i+1] && k == 4'h0 && i != 0) begin
        k = 4'(i);
      end
    end
    if (!(v <= xs[1])) begin
      k = (k == 4'h0) ? 4'h0 : k;
    end else begin
      k = 4'h0;
    end
    // Equal neighbours would divide by zero; hold the lower y instead
    dx = 40'(xs[k+1]) - 40'(xs[k]);
    if (dx == 40'sh0) return ys[k];
    q = ((40'(v) - 40'(xs[k])) * (40'(ys[k+1]) - 40'(ys[k]))) / dx;
    return sat(40'(ys[k]) + q);
  endfunction

  function automatic logic [1:0] range_state(input logic signed [15:0] raw,
                                             input logic cur);
    if (raw > (cur ? dlt_pkg::I_OVER : dlt_pkg::V_OVER)) return 2'h2;
    if (raw < (cur ? dlt_pkg::I_UNDER : dlt_pkg::V_UNDER)) return 2'h1;
    return 2'h0;
  endfunction

  // ------------------------------------------------------------------
  // State and combinational helpers
  // ------------------------------------------------------------------
  dlt_pkg::dlt_state_type r;
  dlt_pkg::dlt_state_type n;
  logic                   cmd_edge;
  logic                   ent_edge;
  logic                   tick;
  logic                   tare_en;
  logic                   teach_en;
  logic                   order_bad;
  logic [1:0]             rs_a;
  logic [1:0]             rs_b;
  logic [3:0]             rng_code;
  logic [1:0]             lin_mode;
  dlt_pkg::dlt_val_type   src;
  dlt_pkg::dlt_val_type   tared;
  dlt_pkg::dlt_val_type   mag;
  dlt_pkg::dlt_val_type   lin_out;
  logic                   wr;
  logic                   rd;
  logic                   pt_hit;
  logic [3:0]             pt_idx;

  assign cmd_edge = KEY_CMD & ~r.cmd_q;
  assign ent_edge = KEY_ENTER & ~r.ent_q;
  assign tick     = (r.pre == 16'(TICK_CYCLES - 1));
  assign tare_en  = r.ctrl[dlt_pkg::F_CMDFN +: 2] == dlt_pkg::CMD_TARE
                 || r.ctrl[dlt_pkg::F_CMDFN +: 2] == dlt_pkg::CMD_BOTH;
  assign teach_en = r.ctrl[dlt_pkg::F_CMDFN +: 2] == dlt_pkg::CMD_TEACH
                 || r.ctrl[dlt_pkg::F_CMDFN +: 2] == dlt_pkg::CMD_BOTH;
  assign lin_mode = r.ctrl[dlt_pkg::F_LINMD +: 2];
  // Combined modes hand over their result already computed
  assign src      = (r.ctrl[dlt_pkg::F_OPMODE +: 3] <= dlt_pkg::OP_DUAL)
                    ? MEAS_A : MEAS_COMB;
  assign tared    = sat(40'(src) - 40'(r.offs));
  assign mag      = tared < 0 ? -tared : tared;
  always_comb begin
    lin_out = tared;
    if (lin_mode == dlt_pkg::LIN_ONE_QUAD) begin
      lin_out = lin(tared, r.px, r.py);
    end else if (lin_mode == dlt_pkg::LIN_FOUR_QUAD) begin
      // Curve mirrored through the origin for negative readings
      lin_out = tared < 0 ? -lin(mag, r.px, r.py) : lin(mag, r.px, r.py);
    end
  end
  assign order_bad = r.idx != 4'h0 && tared <= r.sx[r.idx - 4'h1];
  assign rs_a      = range_state(RAW_A, r.ctrl[dlt_pkg::F_CUR_A]);
  assign rs_b      = range_state(RAW_B, r.ctrl[dlt_pkg::F_CUR_B]);
  assign rng_code  = {2'h0, rs_a} * 4'h3 + {2'h0, rs_b};
  assign wr        = PSEL & PENABLE & PWRITE;
  assign rd        = PSEL & ~PENABLE & ~PWRITE;
  assign pt_hit    = PADDR >= dlt_pkg::A_PT_LO && PADDR <= dlt_pkg::A_PT_HI;
  assign pt_idx    = 4'((PADDR - dlt_pkg::A_PT_LO) >> 3);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n       = r;
    n.cmd_q = KEY_CMD;
    n.ent_q = KEY_ENTER;
    n.pre   = tick ? 16'h0000 : r.pre + 16'h0001;
    if (!(KEY_CMD || KEY_ENTER) || cmd_edge || ent_edge) begin
      n.hold = 14'h0000;
    end else if (tick && r.hold != 14'h3FFF) begin
      n.hold = r.hold + 14'h0001;
    end
    if (tick && r.tmr != 14'h3FFF) begin
      n.tmr = r.tmr + 14'h0001;
    end
    // Register bus
    if (PSEL && !PENABLE) begin
      n.perr   = !(pt_hit || PADDR == dlt_pkg::A_CTRL || PADDR == dlt_pkg::A_OFFS
                   || (!PWRITE && (PADDR == dlt_pkg::A_STAT
                                   || PADDR == dlt_pkg::A_DISP)))
                 || PADDR[1:0] != 2'h0;
      n.prdata = 32'h0000_0000;
    end
    if (rd) begin
      case (PADDR)
        dlt_pkg::A_CTRL: n.prdata = {23'h00_0000, r.ctrl};
        dlt_pkg::A_OFFS: n.prdata = 32'(r.offs);
        dlt_pkg::A_STAT: n.prdata = {16'h0000, rng_code, r.idx, rs_b, rs_a, r.st};
        dlt_pkg::A_DISP: n.prdata = 32'(r.disp.val);
        default: begin
          if (pt_hit) begin
            n.prdata = 32'(PADDR[2] ? r.py[pt_idx] : r.px[pt_idx]);
          end
        end
      endcase
    end
    if (wr && !r.perr) begin
      if (PADDR == dlt_pkg::A_CTRL) begin
        n.ctrl = PWDATA[8:0];
      end else if (PADDR == dlt_pkg::A_OFFS) begin
        n.offs = sat(40'($signed(PWDATA)));
      end else if (pt_hit) begin
        // No ordering check on direct entry
        if (PADDR[2]) begin
          n.py[pt_idx] = sat(40'($signed(PWDATA)));
        end else begin
          n.px[pt_idx] = sat(40'($signed(PWDATA)));
        end
      end
    end
    // Teach sequencer
    case (r.st)
      dlt_pkg::ST_NORMAL: begin
        if (cmd_edge && tare_en) begin
          n.offs = src;
        end
        if (KEY_CMD && teach_en && r.hold >= dlt_pkg::HOLD_TEACH_TK) begin
          n.st  = dlt_pkg::ST_ARMED;
          n.tmr = 14'h0000;
        end
      end
      dlt_pkg::ST_ARMED: begin
        if (cmd_edge || ent_edge) begin
          n.tmr = 14'h0000;
        end
        if (KEY_ENTER && r.hold >= dlt_pkg::HOLD_STOP_TK) begin
          n.st  = dlt_pkg::ST_STOP;
          n.tmr = dlt_pkg::STOP_TK - dlt_pkg::STOP_SHORT_TK;
        end else if (cmd_edge) begin
          n.st  = dlt_pkg::ST_XLBL;
          n.idx = 4'h0;
          for (int i = 0; i < dlt_pkg::NPTS; i++) begin
            n.sx[i] = i == 0 ? dlt_pkg::VAL_MIN : dlt_pkg::VAL_MAX;
            n.sy[i] = i == 0 ? dlt_pkg::VAL_MIN : dlt_pkg::VAL_MAX;
          end
        end else if (r.tmr >= dlt_pkg::IDLE_TK) begin
          n.st = dlt_pkg::ST_NORMAL;
        end
      end
      dlt_pkg::ST_XLBL: begin
        if (cmd_edge) n.st = dlt_pkg::ST_LIVE;
      end
      dlt_pkg::ST_LIVE: begin
        if (cmd_edge && order_bad) begin
          n.st = dlt_pkg::ST_ERR;
        end else if (cmd_edge) begin
          n.sx[r.idx] = tared;
          n.edit      = tared;
          n.tmr       = 14'h0000;
          n.st        = dlt_pkg::ST_YLBL;
        end
      end
      dlt_pkg::ST_ERR: begin
        if (cmd_edge) n.st = dlt_pkg::ST_LIVE;
      end
      dlt_pkg::ST_YLBL: begin
        if (r.tmr >= dlt_pkg::YLBL_TK) n.st = dlt_pkg::ST_YEDIT;
      end
      dlt_pkg::ST_YEDIT: begin
        if (EDIT_LOAD) n.edit = EDIT_VALUE;
        if (cmd_edge) begin
          n.sy[r.idx] = r.edit;
          n.idx       = r.idx + 4'h1;
          n.st        = dlt_pkg::ST_XLBL;
        end
      end
      dlt_pkg::ST_STOP: begin
        if (r.tmr >= dlt_pkg::STOP_TK) n.st = dlt_pkg::ST_NORMAL;
      end
      default: n.st = dlt_pkg::ST_NORMAL;
    endcase
    if (ent_edge && r.st != dlt_pkg::ST_NORMAL && r.st != dlt_pkg::ST_ARMED
        && r.st != dlt_pkg::ST_STOP) begin
      n.px  = r.sx;
      n.py  = r.sy;
      n.st  = dlt_pkg::ST_STOP;
      n.tmr = 14'h0000;
    end
    // Display, refreshed every cycle so range flags win at once in normal and live states
    n.disp.point = r.idx;
    n.disp.blink = r.st == dlt_pkg::ST_LIVE && order_bad;
    n.disp.val   = lin_out;
    n.disp.msg   = dlt_pkg::MSG_VALUE;
    case (r.st)
      dlt_pkg::ST_ARMED: n.disp.msg = dlt_pkg::MSG_TEACH;
      dlt_pkg::ST_STOP:  n.disp.msg = dlt_pkg::MSG_STOP;
      dlt_pkg::ST_XLBL:  n.disp.msg = dlt_pkg::MSG_XLBL;
      dlt_pkg::ST_YLBL:  n.disp.msg = dlt_pkg::MSG_YLBL;
      dlt_pkg::ST_ERR:   n.disp.msg = dlt_pkg::MSG_ERR;
      dlt_pkg::ST_LIVE:  n.disp.val = tared;
      dlt_pkg::ST_YEDIT: n.disp.val = r.edit;
      default:           n.disp.val = lin_out;
    endcase
    if (rng_code != 4'h0 && (r.st == dlt_pkg::ST_NORMAL || r.st == dlt_pkg::ST_LIVE)) begin
      n.disp.msg = rng_code;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      r      <= '0;
      r.st   <= dlt_pkg::ST_NORMAL;
      r.ctrl <= dlt_pkg::CTRL_RST;
      for (int i = 0; i < dlt_pkg::NPTS; i++) begin
        r.px[i] <= dlt_pkg::VAL_MAX;
        r.py[i] <= dlt_pkg::VAL_MAX;
        r.sx[i] <= dlt_pkg::VAL_MAX;
        r.sy[i] <= dlt_pkg::VAL_MAX;
      end
    end else begin
      r <= n;
    end
  end

  assign PRDATA  = r.prdata;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & r.perr;
  assign DISP    = r.disp;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_tare;
    @(posedge CLOCK) disable iff (!ARST_N)
    (r.st == dlt_pkg::ST_NORMAL && cmd_edge && tare_en && !(wr && PADDR == dlt_pkg::A_OFFS))
      |=> r.offs == $past(src);
  endproperty
  a_tare: assert property (p_tare) else $error("tare did not capture value");

  property p_pass;
    @(posedge CLOCK) disable iff (!ARST_N)
    (lin_mode != dlt_pkg::LIN_ONE_QUAD && lin_mode != dlt_pkg::LIN_FOUR_QUAD
     && r.st == dlt_pkg::ST_NORMAL && rng_code == 4'h0) |=> DISP.val == $past(tared);
  endproperty
  a_pass: assert property (p_pass) else $error("value altered with linearizer off");

  property p_low;
    @(posedge CLOCK) disable iff (!ARST_N)
    (lin_mode == dlt_pkg::LIN_ONE_QUAD && tared < r.px[0]) |-> lin_out == r.py[0];
  endproperty
  a_low: assert property (p_low) else $error("below first x not first y");

  property p_high;
    @(posedge CLOCK) disable iff (!ARST_N)
    (lin_mode == dlt_pkg::LIN_ONE_QUAD && tared > r.px[dlt_pkg::NPTS-1])
      |-> lin_out == r.py[dlt_pkg::NPTS-1];
  endproperty
  a_high: assert property (p_high) else $error("above last x not last y");

  property p_gate;
    @(posedge CLOCK) disable iff (!ARST_N)
    (r.st == dlt_pkg::ST_NORMAL && !teach_en) |=> r.st == dlt_pkg::ST_NORMAL;
  endproperty
  a_gate: assert property (p_gate) else $error("teach entered while disabled");

  property p_preset;
    @(posedge CLOCK) disable iff (!ARST_N)
    (r.st == dlt_pkg::ST_ARMED && cmd_edge && !KEY_ENTER)
      |=> r.st == dlt_pkg::ST_XLBL && r.sx[0] == dlt_pkg::VAL_MIN
          && r.sy[1] == dlt_pkg::VAL_MAX && r.idx == 4'h0;
  endproperty
  a_preset: assert property (p_preset) else $error("procedure start wrong");

  property p_order;
    @(posedge CLOCK) disable iff (!ARST_N)
    (r.st == dlt_pkg::ST_LIVE && cmd_edge && order_bad && !KEY_ENTER)
      |=> r.st == dlt_pkg::ST_ERR && r.sx == $past(r.sx) ##1 DISP.msg == dlt_pkg::MSG_ERR;
  endproperty
  a_order: assert property (p_order) else $error("bad x was stored");

  property p_wrap;
    @(posedge CLOCK) disable iff (!ARST_N)
    (r.st == dlt_pkg::ST_YEDIT && cmd_edge && !KEY_ENTER && r.idx == 4'hF)
      |=> r.idx == 4'h0 && r.st == dlt_pkg::ST_XLBL;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap after last point");

  property p_commit;
    @(posedge CLOCK) disable iff (!ARST_N)
    (ent_edge && r.st != dlt_pkg::ST_NORMAL && r.st != dlt_pkg::ST_ARMED
     && r.st != dlt_pkg::ST_STOP)
      |=> r.px == $past(r.sx) && r.st == dlt_pkg::ST_STOP ##1 DISP.msg == dlt_pkg::MSG_STOP;
  endproperty
  a_commit: assert property (p_commit) else $error("stop did not commit");

  property p_range;
    @(posedge CLOCK) disable iff (!ARST_N)
    (r.st == dlt_pkg::ST_NORMAL && rs_a == 2'h2 && rs_b == 2'h1 && !KEY_CMD)
      |=> DISP.msg == 4'h7;
  endproperty
  a_range: assert property (p_range) else $error("range message missing");
endmodule
`default_nettype wire

// ---- dlt_front.sv ----
// Keypad and scaled measurement front end model
`timescale 1ns/1ps
`default_nettype none
module dlt_front #(
  parameter int TICK_CYCLES = 4
) (
  input  wire logic            clk,
  output dlt_pkg::dlt_val_type meas_a,
  output dlt_pkg::dlt_val_type meas_comb,
  output logic signed [15:0]   raw_a,
  output logic signed [15:0]   raw_b,
  output logic                 key_cmd,
  output logic                 key_ent,
  output dlt_pkg::dlt_val_type edit_val,
  output logic                 edit_ld
);
  initial begin
    {meas_a, meas_comb, raw_a, raw_b, edit_val} = '0;
    {key_cmd, key_ent, edit_ld} = 3'b000;
  end
  // Two spare ticks, the hold timer may count one tick late
  task automatic hold(input bit ent, input int ms);
    @(posedge clk);
    key_cmd <= !ent;
    key_ent <= ent;
    repeat ((ms + 2) * TICK_CYCLES) @(posedge clk);
    key_cmd <= 1'b0;
    key_ent <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic measure(input int a, input int c, input int ra, input int rb);
    @(posedge clk);
    meas_a <= 18'(a);
    meas_comb <= 18'(c);
    raw_a <= 16'(ra);
    raw_b <= 16'(rb);
    repeat (20) @(posedge clk);
  endtask
  task automatic edit(input int y);
    @(posedge clk);
    edit_val <= 18'(y);
    edit_ld <= 1'b1;
    @(posedge clk);
    edit_ld <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- dlt_linearizer_tb.sv ----
// Self-checking bench of tare, linearizer, range messages and teach
`timescale 1ns/1ps
`default_nettype none
module dlt_linearizer_tb;
  logic                  clock = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0000_0000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  kc;
  logic                  ke;
  logic                  el;
  logic signed [15:0]    ra;
  logic signed [15:0]    rb;
  dlt_pkg::dlt_val_type  ma;
  dlt_pkg::dlt_val_type  mc;
  dlt_pkg::dlt_val_type  ev;
  dlt_pkg::dlt_disp_type disp;
  logic [64:0]           expq[$];
  int                    n_fail = 0;
  int                    checked = 0;
  int                    cyc = 0;
  int                    seed = 32'ha7b6;
  int                    rv[3];
  int                    tc[8][4] = '{'{32'h20, 3000, 0, 2700}, '{32'h20, 3500, 0, 3750},
    '{32'h20, -50, 0, -99999}, '{32'h20, 15500, 0, 67500}, '{32'h40, -3000, 0, -2700},
    '{32'h21, 3000, 9000, 2700}, '{32'h22, 3000, 9000, 24300}, '{32'h00, 3500, 0, 3500}};
  always #12.5 clock = ~clock;
  dlt_linearizer #(.TICK_CYCLES(2)) dlt_linearizer_inst (.CLOCK(clock), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MEAS_A(ma), .MEAS_COMB(mc),
    .RAW_A(ra), .RAW_B(rb), .KEY_CMD(kc), .KEY_ENTER(ke), .EDIT_VALUE(ev), .EDIT_LOAD(el),
    .DISP(disp));
  dlt_front #(.TICK_CYCLES(2)) dlt_front_inst (.clk(clock), .meas_a(ma), .meas_comb(mc),
    .raw_a(ra), .raw_b(rb), .key_cmd(kc), .key_ent(ke), .edit_val(ev), .edit_ld(el));
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Display flags judged off the edge, once settled
  task automatic chk_disp(input logic [8:0] e);
    @(negedge clock);
    chk({24'h00_0000, disp.msg, disp.point, disp.blink}, {24'h00_0000, e});
  endtask
  // Read results are judged here, against the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      chk({pslverr, prdata & expq[0][63:32]}, {expq[0][64], expq[0][31:0]});
      void'(expq.pop_front());
    end
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      results();
    end
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    xfer(a, 1'b1, 32'(d));
  endtask
  task automatic rd(input logic [7:0] a, input int e, input logic [31:0] m = 32'hFFFF_FFFF);
    expq.push_back({1'b0, m, 32'(e)});
    xfer(a, 1'b0, 32'h0000_0000);
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    rd(dlt_pkg::A_CTRL, 0);
    rd(dlt_pkg::A_PT_HI, 99999);
    expq.push_back({1'b1, 64'h0000_0000_0000_0000});
    xfer(8'h10, 1'b0, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      rv[0] = $random(seed) % 99999;
      dlt_front_inst.measure(rv[0], 0, 0, 0);
      rd(dlt_pkg::A_DISP, rv[0]);
    end
    for (int i = 0; i < 16; i++) begin
      wr(dlt_pkg::A_PT_LO + 8'(8 * i), 1000 * i);
      wr(dlt_pkg::A_PT_LO + 8'(8 * i + 4), 300 * i * i);
    end
    wr(dlt_pkg::A_PT_LO + 8'h04, -200000);
    rd(dlt_pkg::A_PT_LO + 8'h04, -99999);
    for (int i = 0; i < 8; i++) begin
      wr(dlt_pkg::A_CTRL, tc[i][0]);
      dlt_front_inst.measure(tc[i][1], tc[i][2], 0, 0);
      rd(dlt_pkg::A_DISP, tc[i][3]);
    end
    rv = '{$random(seed) % 500, int'(dlt_pkg::V_UNDER) - 1, int'(dlt_pkg::V_OVER) + 1};
    wr(dlt_pkg::A_CTRL, 0);
    for (int a = 0; a < 3; a++) begin
      for (int b = 0; b < 3; b++) begin
        dlt_front_inst.measure(0, 0, rv[a], rv[b]);
        rd(dlt_pkg::A_STAT, ((3 * a + b) << 12) | (b << 6) | (a << 4));
        chk_disp({4'(3 * a + b), 4'h0, 1'b0});
      end
    end
    wr(dlt_pkg::A_CTRL, 32'h0000_0100);
    dlt_front_inst.measure(0, 0, 0, int'(dlt_pkg::I_UNDER) - 1);
    rd(dlt_pkg::A_STAT, 32'h0000_1040);
    dlt_front_inst.measure(0, 0, 0, int'(dlt_pkg::V_OVER) + 1);
    rd(dlt_pkg::A_STAT, 0);
    dlt_front_inst.measure(777, 0, 0, 0);
    wr(dlt_pkg::A_CTRL, 32'h0000_0008);
    dlt_front_inst.hold(1'b0, 3000);
    rd(dlt_pkg::A_STAT, 0);
    rd(dlt_pkg::A_OFFS, 777);
    dlt_front_inst.measure(1000, 0, 0, 0);
    rd(dlt_pkg::A_DISP, 223);
    wr(dlt_pkg::A_OFFS, 0);
    wr(dlt_pkg::A_CTRL, 32'h0000_0010);
    dlt_front_inst.hold(1'b0, 3000);
    rd(dlt_pkg::A_STAT, 1);
    chk_disp({dlt_pkg::MSG_TEACH, 4'h0, 1'b0});
    dlt_front_inst.hold(1'b1, 2000);
    rd(dlt_pkg::A_STAT, 7);
    repeat (2000) @(posedge clock);
    rd(dlt_pkg::A_STAT, 0);
    rd(dlt_pkg::A_PT_LO, 0);
    dlt_front_inst.hold(1'b0, 3000);
    repeat (20010) @(posedge clock);
    rd(dlt_pkg::A_STAT, 0);
    rd(dlt_pkg::A_PT_LO + 8'h04, -99999);
    dlt_front_inst.hold(1'b0, 3000);
    dlt_front_inst.hold(1'b0, 0);
    rd(dlt_pkg::A_STAT, 2);
    chk_disp({dlt_pkg::MSG_XLBL, 4'h0, 1'b0});
    dlt_front_inst.hold(1'b0, 0);
    dlt_front_inst.measure(100, 0, 0, 0);
    dlt_front_inst.hold(1'b0, 0);
    rd(dlt_pkg::A_STAT, 4);
    chk_disp({dlt_pkg::MSG_YLBL, 4'h0, 1'b0});
    repeat (4008) @(posedge clock);
    rd(dlt_pkg::A_STAT, 5);
    rd(dlt_pkg::A_DISP, 100);
    dlt_front_inst.edit(555);
    dlt_front_inst.hold(1'b0, 0);
    rd(dlt_pkg::A_STAT, 32'h0000_0102);
    dlt_front_inst.hold(1'b0, 0);
    dlt_front_inst.measure(50, 0, 0, 0);
    chk_disp({dlt_pkg::MSG_VALUE, 4'h1, 1'b1});
    dlt_front_inst.hold(1'b0, 0);
    rd(dlt_pkg::A_STAT, 32'h0000_0106);
    chk_disp({dlt_pkg::MSG_ERR, 4'h1, 1'b0});
    dlt_front_inst.hold(1'b0, 0);
    rd(dlt_pkg::A_STAT, 32'h0000_0103);
    dlt_front_inst.measure(200, 0, 0, 0);
    dlt_front_inst.hold(1'b0, 0);
    repeat (4008) @(posedge clock);
    dlt_front_inst.edit(666);
    dlt_front_inst.hold(1'b0, 0);
    rd(dlt_pkg::A_STAT, 32'h0000_0202);
    dlt_front_inst.hold(1'b1, 0);
    rd(dlt_pkg::A_STAT, 7, 32'h0000_000F);
    chk_disp({dlt_pkg::MSG_STOP, 4'h2, 1'b0});
    repeat (8008) @(posedge clock);
    rd(dlt_pkg::A_STAT, 0, 32'h0000_000F);
    rd(dlt_pkg::A_PT_LO, 100);
    rd(dlt_pkg::A_PT_LO + 8'h04, 555);
    rd(dlt_pkg::A_PT_LO + 8'h0C, 666);
    rd(dlt_pkg::A_PT_LO + 8'h10, 99999);
    rd(dlt_pkg::A_PT_HI, 99999);
    results();
  end
endmodule
`default_nettype wire
